// ---- include/sec_pkg.sv ----
// Constants and carrier types for the socket status-change event block.
// Assumes a single host-side clock; card pins arrive already synchronous to it.
package sec_pkg;

  // Register offsets in socket space and in the legacy index space.
  localparam logic [11:0] SOCK_STATUS_OFS   = 12'h804;
  localparam logic [11:0] SOCK_CONFIG_OFS   = 12'h805;
  localparam logic [11:0] LEG_A_STATUS_OFS  = 12'h004;
  localparam logic [11:0] LEG_A_CONFIG_OFS  = 12'h005;
  localparam logic [11:0] LEG_B_STATUS_OFS  = 12'h044;
  localparam logic [11:0] LEG_B_CONFIG_OFS  = 12'h045;

  // Reset values.
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam logic [7:0]  CONFIG_RESET      = 8'h00;

  // Status bit positions; the same positions hold the source mask bits.
  localparam int          BIT_BAT_DEAD      = 0;
  localparam int          BIT_BAT_LOW       = 1;
  localparam int          BIT_READY         = 2;
  localparam int          BIT_CARD_DETECT   = 3;
  localparam int          NUM_SOURCES       = 4;

  // Routing select field of the configuration register.
  localparam int          ROUTE_LSB         = 4;
  localparam int          ROUTE_W           = 4;

  // Idle card pin levels: detects and active-low lines high, ready and ring low.
  // The synchroniser resets to these, so no false edge follows reset.
  localparam logic [5:0]  PINS_IDLE         = 6'h36;

  // Unused upper status bits.
  localparam logic [3:0]  STATUS_UNUSED     = 4'h0;

  // Pins from the card, as seen by the block.
  typedef struct packed {
    logic card_detect_a_n;
    logic card_detect_b_n;
    logic card_ready_in;
    logic battery_warn_n;
    logic card_status_line_n;
    logic ring_indicate_in;
  } sec_card_pins_t;

  // Socket mode bits held by neighbouring control registers.
  typedef struct packed {
    logic ring_mode_enable;
    logic card_kind_select;
    logic clear_by_write;
  } sec_mode_t;

endpackage : sec_pkg

// ---- hw/sec_event_status.sv ----
// Status-change event logic for one 16-bit card socket: status and config registers.
// Assumes a simple host register port; mode bits come from neighbouring registers.
`timescale 1ns/1ps

// How it works
// - Disabled source reads zero in status
// - Enabled source sets bit, raises interrupt
// - Clear by status read or write-one
// - Global clear-mode bit picks one method
// - Status bits seven to four read zero
// - Card-detect level change sets bit three
// - Memory card ready rise sets bit two
// - I/O card holds bit two zero
// - Memory card battery warning sets bit one
// - I/O card holds bit one zero
// - Memory card status line sets bit zero
// - Ring mode: ring input rise sets bit zero
// - Status at 804h, 04h or 44h
// - Config at 805h, 05h or 45h
// - Config holds routing select and masks
// - Ring mode enable bit from control
// - Card kind bit: zero memory, one I/O
module sec_event_status #(
  parameter bit SOCKET_B = 1'b0
) (
  // Clock and reset.
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // Host register port.
  input  wire logic                     reg_legacy_space,
  input  wire logic [11:0]              reg_addr,
  input  wire logic                     reg_rd_en,
  input  wire logic                     reg_wr_en,
  input  wire logic [7:0]               reg_wr_data,
  output logic      [7:0]               reg_rd_data,
  output logic                          reg_rd_valid,
  // Socket mode bits.
  input  wire sec_pkg::sec_mode_t       socket_mode,
  // Card pins.
  input  wire sec_pkg::sec_card_pins_t  card_pins,
  // Host side results.
  output logic                          socket_event_interrupt,
  output logic [sec_pkg::ROUTE_W-1:0]   event_route_select
);

  localparam int NS = sec_pkg::NUM_SOURCES;

  logic [7:0]    status_reg;
  logic [7:0]    config_reg;
  logic [5:0]    sync1_reg;
  logic [5:0]    sync2_reg;
  logic [5:0]    prev_reg;
  logic [NS-1:0] event_set;
  logic [NS-1:0] clear_mask;
  logic [NS-1:0] status_next;
  logic [NS-1:0] masks;
  logic          hit_status;
  logic          hit_config;
  logic          io_card;
  logic          ring_mode;
  logic          bit0_level;
  logic          bit0_prev;

  // Address decode for socket space and the legacy index of this socket.
  always_comb begin
    if (reg_legacy_space) begin
      hit_status = reg_addr == (SOCKET_B ? sec_pkg::LEG_B_STATUS_OFS
                                         : sec_pkg::LEG_A_STATUS_OFS);
      hit_config = reg_addr == (SOCKET_B ? sec_pkg::LEG_B_CONFIG_OFS
                                         : sec_pkg::LEG_A_CONFIG_OFS);
    end else begin
      hit_status = reg_addr == sec_pkg::SOCK_STATUS_OFS;
      hit_config = reg_addr == sec_pkg::SOCK_CONFIG_OFS;
    end
  end

  // Two-stage synchroniser, then one more stage that the edge detectors compare against.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_reg <= sec_pkg::PINS_IDLE;
      sync2_reg <= sec_pkg::PINS_IDLE;
      prev_reg  <= sec_pkg::PINS_IDLE;
    end else begin
      sync1_reg <= card_pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign io_card   = socket_mode.card_kind_select;
  assign ring_mode = socket_mode.ring_mode_enable;
  assign masks     = config_reg[NS-1:0];

  // Struct field order: detect_a=5, detect_b=4, ready=3, warn_n=2, status_n=1, ring=0.
  // Bit zero source: ring input in ring mode, otherwise the asserted status line.
  assign bit0_level = ring_mode ? sync2_reg[0] : ~sync2_reg[1];
  assign bit0_prev  = ring_mode ? prev_reg[0]  : ~prev_reg[1];

  // Raw events; a source that is masked off never records anything.
  always_comb begin
    event_set = '0;
    event_set[sec_pkg::BIT_CARD_DETECT] = (sync2_reg[5] != prev_reg[5])
                                        | (sync2_reg[4] != prev_reg[4]);
    event_set[sec_pkg::BIT_READY]       = ~io_card & sync2_reg[3]
                                        & ~prev_reg[3];
    event_set[sec_pkg::BIT_BAT_LOW]     = ~io_card & ~sync2_reg[2]
                                        & prev_reg[2];
    event_set[sec_pkg::BIT_BAT_DEAD]    = bit0_level & ~bit0_prev;
    event_set = event_set & masks;
  end

  // Only the clear method picked by the global mode bit is honoured.
  always_comb begin
    clear_mask = '0;
    if (socket_mode.clear_by_write) begin
      if (reg_wr_en && hit_status) begin
        clear_mask = reg_wr_data[NS-1:0];
      end
    end else if (reg_rd_en && hit_status) begin
      clear_mask = '1;
    end
  end

  // Sticky status: a new event in the clearing cycle is kept.
  assign status_next = (status_reg[NS-1:0] & ~clear_mask) | event_set;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_reg <= sec_pkg::STATUS_RESET;
    end else begin
      status_reg <= {sec_pkg::STATUS_UNUSED, status_next};
    end
  end

  // I/O card forces the ready and battery-low bits to read zero at all times.
  logic [NS-1:0] status_view;
  always_comb begin
    status_view = status_reg[NS-1:0] & masks;
    if (io_card) begin
      status_view[sec_pkg::BIT_READY]   = 1'b0;
      status_view[sec_pkg::BIT_BAT_LOW] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      config_reg <= sec_pkg::CONFIG_RESET;
    end else if (reg_wr_en && hit_config) begin
      config_reg <= reg_wr_data;
    end
  end

  // Read data is registered; the read-clear takes effect on the same edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en && hit_status) begin
        reg_rd_data <= {sec_pkg::STATUS_UNUSED, status_view};
      end else if (reg_rd_en && hit_config) begin
        reg_rd_data <= config_reg;
      end else if (reg_rd_en) begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  assign socket_event_interrupt = |status_view;
  assign event_route_select =
    config_reg[sec_pkg::ROUTE_LSB +: sec_pkg::ROUTE_W];

endmodule : sec_event_status

// ---- testbench/sec_event_status_props.sv ----
// Port checker for the socket status-change block.
// Assumes the bind at the foot; card pins are synchronous to clk_sys.
`timescale 1ns/1ps
module sec_event_status_props #(
  parameter bit SOCKET_B = 1'b0
) (
  // Clock, reset and register port.
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  input wire logic                        reg_legacy_space,
  input wire logic [11:0]                 reg_addr,
  input wire logic                        reg_rd_en,
  input wire logic                        reg_wr_en,
  input wire logic [7:0]                  reg_wr_data,
  input wire logic [7:0]                  reg_rd_data,
  input wire logic                        reg_rd_valid,
  // Modes, pins and results.
  input wire sec_pkg::sec_mode_t          socket_mode,
  input wire sec_pkg::sec_card_pins_t     card_pins,
  input wire logic                        socket_event_interrupt,
  input wire logic [sec_pkg::ROUTE_W-1:0] event_route_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [2:0] quiet;
  wire        st_hit = reg_addr == 12'h804 && !reg_legacy_space;
  // Counts edges with steady pins, so no event can be in flight.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !$stable(card_pins)) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  a_rd_answers: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read gave no answer");
  a_unmapped_zero: assert property (reg_rd_en && reg_addr[11:1] != (reg_legacy_space ?
    (SOCKET_B ? 11'h022 : 11'h002) : 11'h402) |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (reg_rd_en && !reg_addr[0] |=> reg_rd_data[7:4] == 4'h0)
    else $error("status upper bits set");
  a_route_write: assert property (reg_wr_en && reg_addr == 12'h805 && !reg_legacy_space
    |=> event_route_select == $past(reg_wr_data[7:4])) else $error("route not written");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !socket_event_interrupt &&
    event_route_select == 4'h0 && !reg_rd_valid) else $error("outputs not reset");
  a_read_clears: assert property (socket_event_interrupt && reg_rd_en && st_hit &&
    !socket_mode.clear_by_write && quiet > 3'h3 |=> !socket_event_interrupt)
    else $error("status read did not clear");
  a_write_clears: assert property (socket_event_interrupt && reg_wr_en && st_hit &&
    socket_mode.clear_by_write && reg_wr_data[3:0] == 4'hf && quiet > 3'h3
    |=> !socket_event_interrupt) else $error("write of ones did not clear");
  a_irq_sticky: assert property (socket_event_interrupt && !reg_rd_en && !reg_wr_en
    ##1 $stable(socket_mode) |-> socket_event_interrupt) else $error("interrupt dropped");
  c_irq: cover property ($rose(socket_event_interrupt));
  c_rd_clear: cover property (st_hit && reg_rd_en && socket_event_interrupt);
  c_wr_clear: cover property (st_hit && reg_wr_en && socket_mode.clear_by_write);
endmodule : sec_event_status_props
bind sec_event_status sec_event_status_props #(.SOCKET_B(SOCKET_B)) u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_legacy_space(reg_legacy_space),
  .reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .socket_mode(socket_mode), .card_pins(card_pins),
  .socket_event_interrupt(socket_event_interrupt), .event_route_select(event_route_select));

// ---- testbench/sec_card_model.sv ----
// Model of the 16-bit card in the socket: it drives the card pins.
// Assumes the caller changes pins just after a falling clock edge.
`timescale 1ns/1ps
module sec_card_model (
  // Card pins seen by the socket.
  output sec_pkg::sec_card_pins_t pins
);
  initial pins = 6'b110110;
  task automatic drive(input int idx, input logic v);
    pins[idx] = v;
  endtask : drive
endmodule : sec_card_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the socket status-change block.
// Assumes the default legacy offsets of socket A.
`timescale 1ns/1ps
module tb_top;
  logic                    clk_sys = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    legacy = 1'b0;
  logic [11:0]             addr = 12'h000;
  logic                    rd_en = 1'b0;
  logic                    wr_en = 1'b0;
  logic [7:0]              wr_data = 8'h00;
  logic [7:0]              rd_data;
  logic                    rd_valid;
  logic                    irq;
  logic [3:0]              route;
  sec_pkg::sec_mode_t      mode = '0;
  sec_pkg::sec_card_pins_t pins;
  int                      fails = 0;
  int                      num_checks = 0;
  int                      pin_idx [4] = '{5, 3, 2, 1};
  logic [7:0]              exp_bit [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
  always #25 clk_sys = ~clk_sys;
  sec_card_model card (.pins(pins));
  sec_event_status uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_legacy_space(legacy),
    .reg_addr(addr), .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_wr_data(wr_data),
    .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .socket_mode(mode), .card_pins(pins),
    .socket_event_interrupt(irq), .event_route_select(route));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    legacy = !a[11];
    rd_en = !wr;
    wr_en = wr;
    wr_data = d;
    @(negedge clk_sys);
    rd_en = 1'b0;
    wr_en = 1'b0;
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk("read valid", {7'h00, rd_valid}, 8'h01);
    chk("read data", rd_data, exp);
  endtask : rd
  task automatic pin(input int idx, input logic v);
    card.drive(idx, v);
    repeat (4) @(negedge clk_sys);
  endtask : pin
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    rd(12'h804, 8'h00);
    rd(12'h005, 8'h00);
    acc(1'b1, 12'h005, 8'h3f);
    rd(12'h805, 8'h3f);
    chk("route", {4'h0, route}, 8'h03);
    rd(12'h045, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pin(pin_idx[i], i == 1);
      chk("irq set", {7'h00, irq}, 8'h01);
      rd(12'h804, exp_bit[i]);
      chk("irq clear", {7'h00, irq}, 8'h00);
    end
    acc(1'b1, 12'h805, 8'h3e);
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(12'h004, 8'h00);
    mode.clear_by_write = 1'b1;
    pin(4, 1'b0);
    rd(12'h804, 8'h08);
    rd(12'h804, 8'h08);
    acc(1'b1, 12'h804, 8'h0f);
    rd(12'h804, 8'h00);
    mode.card_kind_select = 1'b1;
    pin(3, 1'b0);
    pin(3, 1'b1);
    pin(2, 1'b1);
    pin(2, 1'b0);
    rd(12'h804, 8'h00);
    mode = 3'b101;
    acc(1'b1, 12'h805, 8'h3f);
    pin(0, 1'b1);
    rd(12'h804, 8'h01);
    report_and_stop();
  end
endmodule : tb_top
